/* File: rtl/asc_seq_ctrl.sv */
// module: four-channel converter sequence control, single and scan modes
// What this block does
// - result registers clear to zero on reset, module standby and standby.
// - control/status bits clear to zero on reset, module standby, standby.
// - single mode starts a new sequence on a start write after completion.
// - scan mode repeats the selected channels while the start bit is one.
// - clearing the start bit stops conversion.
// - a scan restart always begins at channel zero.
// - conversion time is counted in peripheral clock states.
// - an external trigger input also starts conversion.
// - four analogue input channels, zero to three.
// - each channel conversion takes at least fifteen microseconds.
`timescale 1ns/1ps
module asc_seq_ctrl #(
    parameter int CONV_CYCLES = asc_pkg::ASC_CONV_CYCLES,
    parameter int RES_W = asc_pkg::ASC_RES_W
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic convModuleStopBit,
    input wire logic standbyMode,
    input wire asc_pkg::asc_cfg_type cfg,
    input wire logic startWrite1,
    input wire logic startWrite0,
    input wire logic endFlagClear,
    input wire logic extConvTrigger,
    input wire logic [RES_W-1:0] analogData,
    input wire logic [asc_pkg::ASC_CHAN_W-1:0] resultIdx,
    output logic [RES_W-1:0] resultData,
    output asc_pkg::asc_status_type status,
    output logic sampleStrobe,
    output logic convIrq
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        asc_pkg::asc_state_type st;
        logic startBit;
        logic [1:0] chan;
        logic endFlag;
        logic irq;
        logic sample;
        logic trigPrev;
    } asc_ctrl_type;

    asc_ctrl_type q;
    asc_ctrl_type d;

    logic clrAll;
    logic tmrDone;
    logic tmrStart;
    logic tmrAbort;
    logic trigEdge;
    logic startReq;
    logic memWe;

    // ****************************************************************
    // helpers
    // ****************************************************************
    // next scan channel, wrapping after the last selected one
    function automatic logic [1:0] asc_next_chan(
        input logic [1:0] cur,
        input logic [1:0] last
    );
        logic [1:0] nxt;
        nxt = asc_pkg::ASC_FIRST_CHAN;
        if (cur != last && cur != asc_pkg::ASC_LAST_CHAN)
            nxt = cur + 2'h1;
        return nxt;
    endfunction : asc_next_chan

    // first channel of a fresh sequence
    function automatic logic [1:0] asc_first_chan(
        input asc_pkg::asc_cfg_type c
    );
        logic [1:0] f;
        f = c.lastChan;
        if (c.scanMode)
            f = asc_pkg::ASC_FIRST_CHAN;
        return f;
    endfunction : asc_first_chan

    // module stop and standby hold the whole block cleared
    assign clrAll = rst | convModuleStopBit | standbyMode;

    // rising edge on the trigger pin, when software allows it
    assign trigEdge = cfg.extTrigEn & extConvTrigger & ~q.trigPrev;

    // a start write, or the trigger, with no stop write in the same cycle
    assign startReq = (startWrite1 | trigEdge) & ~startWrite0;

    // ****************************************************************
    // sequencer
    // ****************************************************************
    always_comb
    begin
        d = q;
        d.sample = 1'b0;
        d.trigPrev = extConvTrigger;
        tmrStart = 1'b0;
        tmrAbort = 1'b0;
        memWe = 1'b0;

        unique case (q.st)
            asc_pkg::ST_IDLE:
            begin
                if (startReq)
                begin
                    d.st = asc_pkg::ST_CONV;
                    d.startBit = 1'b1;
                    d.chan = asc_first_chan(cfg);
                    d.sample = 1'b1;
                    tmrStart = 1'b1;
                end
            end
            asc_pkg::ST_CONV:
            begin
                if (startWrite0)
                begin
                    // stop now; the partial result is discarded
                    d.st = asc_pkg::ST_IDLE;
                    d.startBit = 1'b0;
                    tmrAbort = 1'b1;
                end
                else if (tmrDone)
                begin
                    memWe = 1'b1;
                    d.endFlag = 1'b1;
                    if (cfg.scanMode)
                    begin
                        // keep cycling while the start bit stays set
                        d.chan = asc_next_chan(q.chan, cfg.lastChan);
                        d.sample = 1'b1;
                        tmrStart = 1'b1;
                    end
                    else
                    begin
                        d.st = asc_pkg::ST_IDLE;
                        d.startBit = 1'b0;
                    end
                end
            end
        endcase

        // a flag set in the same cycle as its clear is kept
        if (endFlagClear && !(memWe))
            d.endFlag = 1'b0;

        d.irq = d.endFlag & cfg.convEndIe;
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge mclk)
    begin
        if (clrAll)
            q <= '0;
        else
            q <= d;
    end

    // ****************************************************************
    // conversion timer and result store
    // ****************************************************************
    asc_timer #(
        .CNT_W(asc_pkg::ASC_CNT_W),
        .CYCLES(CONV_CYCLES)
    ) u_timer (
        .mclk(mclk),
        .clr(clrAll),
        .start(tmrStart),
        .abort(tmrAbort),
        .done(tmrDone)
    );

    asc_result_mem #(
        .WORDS(asc_pkg::ASC_NUM_CHAN),
        .AW(asc_pkg::ASC_CHAN_W),
        .DW(RES_W)
    ) u_mem (
        .mclk(mclk),
        .clr(clrAll),
        .we(memWe),
        .wAddr(q.chan),
        .wData(analogData),
        .rAddr(resultIdx),
        .rData(resultData)
    );

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign status.convStartBit = q.startBit;
    assign status.convEndFlag = q.endFlag;
    assign status.busy = (q.st == asc_pkg::ST_CONV);
    assign status.channel = q.chan;
    assign sampleStrobe = q.sample;
    assign convIrq = q.irq;

endmodule : asc_seq_ctrl

/* File: inc/asc_pkg.sv */
// package: constants and carrier types for the converter sequence control
package asc_pkg;

    // ****************************************************************
    // channels and widths
    // ****************************************************************
    localparam int ASC_NUM_CHAN = 4;
    localparam int ASC_CHAN_W = 2;
    localparam int ASC_RES_W = 16;
    localparam logic [1:0] ASC_FIRST_CHAN = 2'h0;
    localparam logic [1:0] ASC_LAST_CHAN = 2'h3;

    // ****************************************************************
    // values after reset and standby
    // ****************************************************************
    localparam logic [15:0] ASC_RESULT_RESET = 16'h0000;
    localparam logic [15:0] ASC_CSR_RESET = 16'h0000;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int ASC_CLK_HZ = 10_000_000;
    localparam int ASC_CONV_TIME_NS = 15000;
    // least time: round up to whole cycles
    localparam int ASC_CONV_CYCLES =
        (ASC_CONV_TIME_NS * (ASC_CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int ASC_CNT_W = 12;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [0:0] {
        ST_IDLE,
        ST_CONV
    } asc_state_type;

    // software settings of the control/status register
    typedef struct packed {
        logic scanMode;
        logic extTrigEn;
        logic convEndIe;
        logic [1:0] lastChan;
    } asc_cfg_type;

    // visible control/status bits
    typedef struct packed {
        logic convStartBit;
        logic convEndFlag;
        logic busy;
        logic [1:0] channel;
    } asc_status_type;

endpackage : asc_pkg

/* File: rtl/asc_timer.sv */
// module: conversion duration counter on the peripheral clock
`timescale 1ns/1ps
module asc_timer #(
    parameter int CNT_W = asc_pkg::ASC_CNT_W,
    parameter int CYCLES = asc_pkg::ASC_CONV_CYCLES
) (
    input wire logic mclk,
    input wire logic clr,
    input wire logic start,
    input wire logic abort,
    output logic done
);

    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic done;
    } asc_tmr_type;

    localparam logic [CNT_W-1:0] LOAD = CNT_W'(CYCLES);
    localparam logic [CNT_W-1:0] ONE = CNT_W'(1);

    asc_tmr_type q;
    asc_tmr_type d;

    // ****************************************************************
    // count down; done pulses CYCLES edges after start
    // ****************************************************************
    always_comb
    begin
        d = q;
        d.done = 1'b0;
        if (abort)
        begin
            d.count = '0;
        end
        else if (start)
        begin
            d.count = LOAD;
        end
        else if (q.count == ONE)
        begin
            d.count = '0;
            d.done = 1'b1;
        end
        else if (q.count != '0)
        begin
            d.count = q.count - ONE;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (clr)
            q <= '0;
        else
            q <= d;
    end

    assign done = q.done;

endmodule : asc_timer

/* File: rtl/asc_result_mem.sv */
// module: per-channel result store with registered read data
`timescale 1ns/1ps
module asc_result_mem #(
    parameter int WORDS = asc_pkg::ASC_NUM_CHAN,
    parameter int AW = asc_pkg::ASC_CHAN_W,
    parameter int DW = asc_pkg::ASC_RES_W
) (
    input wire logic mclk,
    input wire logic clr,
    input wire logic we,
    input wire logic [AW-1:0] wAddr,
    input wire logic [DW-1:0] wData,
    input wire logic [AW-1:0] rAddr,
    output logic [DW-1:0] rData
);

    typedef struct packed {
        logic [WORDS-1:0][DW-1:0] words;
        logic [DW-1:0] rData;
    } asc_mem_type;

    asc_mem_type q;
    asc_mem_type d;

    always_comb
    begin
        d = q;
        if (we)
            d.words[wAddr] = wData;
        d.rData = q.words[rAddr];
    end

    // ****************************************************************
    // every word clears together
    // ****************************************************************
    always_ff @(posedge mclk)
    begin
        if (clr)
            q <= {WORDS + 1{DW'(asc_pkg::ASC_RESULT_RESET)}};
        else
            q <= d;
    end

    assign rData = q.rData;

endmodule : asc_result_mem

/* File: dv/asc_seq_ctrl_properties.sv */
// checker: clearing, start, stop and timing of the sequence control
`timescale 1ns/1ps
module asc_seq_ctrl_properties #(
    parameter int CONV_CYCLES = asc_pkg::ASC_CONV_CYCLES,
    parameter int RES_W = asc_pkg::ASC_RES_W
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic convModuleStopBit,
    input wire logic standbyMode,
    input wire asc_pkg::asc_cfg_type cfg,
    input wire logic startWrite1,
    input wire logic startWrite0,
    input wire logic extConvTrigger,
    input wire logic [RES_W-1:0] resultData,
    input wire asc_pkg::asc_status_type status,
    input wire logic sampleStrobe,
    input wire logic convIrq
);
    logic clr;
    logic go;
    logic [11:0] chanCnt_q;
    assign clr = rst | convModuleStopBit | standbyMode;
    assign go = !clr && !status.busy && startWrite1 && !startWrite0;
    // cycles since the last channel start
    always_ff @(posedge mclk)
    begin
        if (sampleStrobe)
            chanCnt_q <= 12'h001;
        else if (chanCnt_q != 12'hfff)
            chanCnt_q <= chanCnt_q + 12'h001;
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    // ****
    // properties
    // ****
    a_clear_status: assert property (
        clr |=> status == '0 && !sampleStrobe && !convIrq)
        else $error("status not cleared");
    a_clear_result: assert property (
        clr |=> resultData == '0) else $error("result not cleared");
    a_single_start: assert property (
        go && !cfg.scanMode |=> status.busy && status.convStartBit
        && sampleStrobe && status.channel == $past(cfg.lastChan))
        else $error("single start wrong");
    a_scan_first: assert property (
        go && cfg.scanMode |=> status.busy && status.channel == 2'h0)
        else $error("scan not from channel zero");
    a_stop_abort: assert property (
        !clr && status.busy && startWrite0
        |=> !status.busy && !status.convStartBit)
        else $error("stop ignored");
    a_ext_trig: assert property (
        !clr && !status.busy && cfg.extTrigEn && extConvTrigger
        && !$past(extConvTrigger) && !startWrite0 |=> status.busy)
        else $error("trigger ignored");
    a_conv_time: assert property (
        $rose(status.convEndFlag) |-> chanCnt_q == CONV_CYCLES + 1)
        else $error("channel time wrong");
    a_irq_follow: assert property (
        !clr |=> convIrq == (status.convEndFlag & $past(cfg.convEndIe)))
        else $error("irq mismatch");
    c_scan_stop: cover property (status.busy && cfg.scanMode && startWrite0);
    c_single_end: cover property ($fell(status.busy) && status.convEndFlag);
    c_irq: cover property (convIrq);
endmodule : asc_seq_ctrl_properties

bind asc_seq_ctrl asc_seq_ctrl_properties #(.CONV_CYCLES(CONV_CYCLES),
    .RES_W(RES_W)) u_props (.mclk(mclk), .rst(rst),
    .convModuleStopBit(convModuleStopBit), .standbyMode(standbyMode),
    .cfg(cfg), .startWrite1(startWrite1), .startWrite0(startWrite0),
    .extConvTrigger(extConvTrigger), .resultData(resultData),
    .status(status), .sampleStrobe(sampleStrobe), .convIrq(convIrq));

/* File: dv/asc_seq_ctrl_tb.sv */
// bench: cycle model compared with the sequence control
`timescale 1ns/1ps
module asc_seq_ctrl_tb;
    localparam int C = 4;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic modStop = 1'b0;
    logic stby = 1'b0;
    asc_pkg::asc_cfg_type cfg = '0;
    logic wr1 = 1'b0;
    logic wr0 = 1'b0;
    logic flagClr = 1'b0;
    logic trig = 1'b0;
    logic [15:0] ain = 16'h0000;
    logic [1:0] idx = 2'h0;
    logic [15:0] rdat;
    asc_pkg::asc_status_type st;
    logic stb;
    logic irq;
    int n_errors = 0;
    int samples_checked = 0;
    int cyc = 0;
    logic [15:0] rnd = 16'h0050;
    logic [15:0] mR [4];
    logic [15:0] mD;
    logic mB, mS, mF, mI, mT, mP;
    logic [1:0] mC;
    int mN;
    always #50 mclk = ~mclk;
    asc_seq_ctrl #(.CONV_CYCLES(C)) u_dut (.mclk(mclk), .rst(rst),
        .convModuleStopBit(modStop), .standbyMode(stby), .cfg(cfg),
        .startWrite1(wr1), .startWrite0(wr0), .endFlagClear(flagClr),
        .extConvTrigger(trig), .analogData(ain), .resultIdx(idx),
        .resultData(rdat), .status(st), .sampleStrobe(stb), .convIrq(irq));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    task automatic check(input string nm, input logic [15:0] seen,
        input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish
    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask : tick
    task automatic hit(input logic [2:0] p, input int n);
        {wr1, wr0, flagClr} = p;
        tick(1);
        {wr1, wr0, flagClr} = 3'h0;
        tick(n);
    endtask : hit
    // ****
    // reference model, one step per clock edge
    // ****
    always @(posedge mclk)
    begin
        cyc++;
        if (rst | modStop | stby)
        begin
            mR = '{default: 16'h0000};
            {mD, mB, mS, mF, mI, mT, mP, mC, mN} = '0;
        end
        else
        begin
            mD = mR[idx];
            mT = 1'b0;
            if (flagClr)
                mF = 1'b0;
            if (!mB && (wr1 | cfg.extTrigEn & trig & !mP) && !wr0)
            begin
                {mB, mS, mT} = 3'h7;
                mN = 0;
                mC = cfg.scanMode ? 2'h0 : cfg.lastChan;
            end
            else if (mB && wr0)
                {mB, mS} = 2'h0;
            else if (mB)
                mN++;
            // a channel ends one edge after the timer's done flop
            if (mB && mN == C + 1)
            begin
                mR[mC] = ain;
                mF = 1'b1;
                mN = 0;
                {mB, mS, mT} = {3{cfg.scanMode}};
                if (cfg.scanMode)
                    mC = (mC == cfg.lastChan) ? 2'h0 : mC + 2'h1;
            end
            // irq follows the flag as it is being registered
            mI = mF & cfg.convEndIe;
            mP = trig;
        end
        if (cyc > 20000)
        begin
            n_errors++;
            tally_and_finish();
        end
    end
    always @(negedge mclk)
    begin
        check("busy", st.busy, mB);
        check("start", st.convStartBit, mS);
        check("chan", st.channel, mC);
        check("flag", st.convEndFlag, mF);
        check("irq", irq, mI);
        check("strobe", stb, mT);
        check("result", rdat, mD);
    end
    // ****
    // scenarios
    // ****
    initial
    begin
        tick(16);
        rst = 1'b0;
        tick(1);
        for (int i = 0; i < 4; i++)
        begin
            cfg = {2'h0, i[0], i[1:0]};
            ain = 16'h1000 + i[15:0];
            idx = i[1:0];
            hit(3'h4, C + 2);
            hit(3'h1, 1);
        end
        cfg = 5'h16;
        hit(3'h4, 2 * C);
        hit(3'h4, 5 * C);
        hit(3'h2, 2);
        hit(3'h4, 2 * C);
        hit(3'h2, 2);
        cfg = 5'h00;
        trig = 1'b1;
        tick(3);
        trig = 1'b0;
        tick(2);
        cfg = 5'h0b;
        trig = 1'b1;
        tick(C + 3);
        trig = 1'b0;
        cfg = 5'h13;
        for (int k = 0; k < 3; k++)
        begin
            hit(3'h4, 2 * C + 1);
            {rst, modStop, stby} = 3'h4 >> k;
            tick(2);
            {rst, modStop, stby} = 3'h0;
            for (int j = 0; j < 4; j++)
            begin
                idx = j[1:0];
                tick(2);
            end
        end
        for (int b = 0; b < 4; b++)
        begin
            rnd = lfsr(rnd);
            cfg = rnd[4:0];
            repeat (300)
            begin
                rnd = lfsr(rnd);
                {wr1, trig, flagClr, idx} = rnd[4:0];
                wr0 = rnd[9:5] == 5'h00;
                ain = rnd;
                tick(1);
            end
            {wr1, wr0, flagClr, trig} = 4'h4;
            tick(1);
            wr0 = 1'b0;
            tick(C + 2);
        end
        tally_and_finish();
    end
endmodule : asc_seq_ctrl_tb
